/* design/okf_keypad.sv */
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module okf_keypad #(
    parameter logic [31:0] FIRST_CYC = okf_pkg::FIRST_CYC,
    parameter logic [31:0] STEP_CYC = okf_pkg::STEP_CYC,
    parameter logic [31:0] SLOW_CYC = okf_pkg::SLOW_CYC,
    parameter logic [31:0] STORE_CYC = okf_pkg::STORE_CYC
) (
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_running,
    input wire logic i_hour_tick,
    input wire logic i_fan_on,
    input wire logic i_key_local_remote,
    input wire logic i_key_stop,
    input wire logic i_key_up,
    input wire logic i_key_down,
    input wire logic i_key_enter,
    input wire logic [15:0] i_key_value,
    output logic o_local_mode,
    output logic o_stop,
    output logic o_emergency_stop,
    output logic [15:0] o_freq_ref,
    output logic o_store_ref,
    output logic o_save_user_set,
    output logic o_clear_user_set,
    output logic o_user_reload,
    output logic [15:0] o_elapsed_hours,
    output logic [15:0] o_fan_hours,
    output logic [15:0] o_display_scaling,
    output logic [7:0] o_monitor
);

    typedef struct packed {
        logic lr_en;
        logic stop_en;
        logic direct;
        logic [1:0] action;
        logic [1:0] run_sel;
        logic [1:0] ref_sel;
        logic [2:0] pon_mon;
        logic [7:0] user_mon;
        logic [15:0] scale;
        logic [15:0] fmax;
        logic local_mode;
        logic [15:0] freq;
        logic [15:0] elapsed;
        logic [15:0] fan;
        logic saved;
        logic refused;
        logic key_prev;
        logic [31:0] hold_cnt;
        logic [31:0] tick_cnt;
        logic store_pend;
        logic [31:0] store_cnt;
        logic stop;
        logic estop;
        logic store_pulse;
        logic save_pulse;
        logic clear_pulse;
        logic reload_pulse;
        logic [7:0] monitor;
        logic [31:0] rdata;
    } okf_state_s;

    okf_state_s st;
    okf_state_s next_st;

    logic access;
    logic wr_acc;
    logic mapped;
    logic key_up;
    logic key_dn;
    logic held;
    logic [15:0] fast_step;

    ////////////////////////////////////////////////////////////////////////
    // saturating reference step between 0 and fmax
    function automatic logic [15:0] okf_step(input logic [15:0] f,
        input logic [15:0] fmax, input logic [15:0] d, input logic up);
        logic [16:0] sum;
        sum = {1'b0, f} + {1'b0, d};
        if (up)
        begin
            okf_step = (sum > {1'b0, fmax}) ? fmax : sum[15:0];
        end
        else
        begin
            okf_step = (f < d) ? 16'h0000 : f - d;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, read data captured in the setup cycle
    assign access = i_psel && i_penable;
    assign wr_acc = access && i_pwrite && !i_running;
    assign o_pready = 1'b1;
    always_comb
    begin
        case (i_paddr)
            okf_pkg::CTRL_OFS, okf_pkg::SOURCE_OFS, okf_pkg::INIT_OFS,
            okf_pkg::ELAPSED_OFS, okf_pkg::FAN_OFS, okf_pkg::SCALE_OFS,
            okf_pkg::MONITOR_OFS, okf_pkg::FREQ_OFS, okf_pkg::STATUS_OFS,
            okf_pkg::FMAX_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    // a running drive answers any write with an error and keeps its settings
    assign o_pslverr = access && (!mapped || (i_pwrite && i_running));

    assign key_up = i_key_up && !i_key_down;
    assign key_dn = i_key_down && !i_key_up;
    assign held = st.direct && (key_up || key_dn);
    // the fast phase covers 0..fmax in a fixed number of 80 ms ticks
    assign fast_step = (st.fmax < okf_pkg::FAST_STEPS) ? 16'h0001 :
        st.fmax / okf_pkg::FAST_STEPS;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        next_st.stop = 1'b0;
        next_st.estop = 1'b0;
        next_st.store_pulse = 1'b0;
        next_st.save_pulse = 1'b0;
        next_st.clear_pulse = 1'b0;
        next_st.reload_pulse = 1'b0;

        // one-shot action setting: act once, then read back as zero
        case (st.action)
            okf_pkg::ACTION_SAVE:
            begin
                next_st.save_pulse = 1'b1;
                next_st.saved = 1'b1;
                next_st.action = okf_pkg::ACTION_NONE;
            end
            okf_pkg::ACTION_CLEAR:
            begin
                next_st.clear_pulse = 1'b1;
                next_st.saved = 1'b0;
                next_st.action = okf_pkg::ACTION_NONE;
            end
            default: next_st.action = okf_pkg::ACTION_NONE;
        endcase

        // local/remote toggle only when the key is enabled
        if (i_key_local_remote && st.lr_en)
        begin
            next_st.local_mode = !st.local_mode;
        end

        if (i_key_stop)
        begin
            if (st.local_mode || st.run_sel == okf_pkg::RUN_PANEL)
            begin
                next_st.stop = 1'b1;
            end
            else if (st.stop_en)
            begin
                next_st.estop = 1'b1;
            end
        end

        // hour counters run up and stick at full scale
        if (i_hour_tick && i_running && st.elapsed != 16'hffff)
        begin
            next_st.elapsed = st.elapsed + 16'h0001;
        end
        if (i_hour_tick && i_fan_on && st.fan != 16'hffff)
        begin
            next_st.fan = st.fan + 16'h0001;
        end

        // reference entry
        next_st.key_prev = held;
        if (!st.direct)
        begin
            if (i_key_enter)
            begin
                next_st.freq = (i_key_value > st.fmax) ? st.fmax : i_key_value;
            end
            next_st.store_pend = 1'b0;
        end
        else if (held)
        begin
            next_st.store_pend = 1'b0;
            next_st.store_cnt = 32'h0;
            if (!st.key_prev)
            begin
                next_st.hold_cnt = 32'h0;
                next_st.tick_cnt = 32'h0;
                next_st.freq = okf_step(st.freq, st.fmax, 16'h0001,
                    key_up);
            end
            else
            begin
                if (st.hold_cnt != 32'hffffffff)
                begin
                    next_st.hold_cnt = st.hold_cnt + 32'h1;
                end
                if (st.hold_cnt >= FIRST_CYC - 32'h1)
                begin
                    if (st.tick_cnt >= STEP_CYC - 32'h1)
                    begin
                        next_st.tick_cnt = 32'h0;
                        next_st.freq = okf_step(st.freq, st.fmax,
                            (st.hold_cnt >= FIRST_CYC + SLOW_CYC) ?
                            fast_step : 16'h0001, key_up);
                    end
                    else
                    begin
                        next_st.tick_cnt = st.tick_cnt + 32'h1;
                    end
                end
            end
        end
        else
        begin
            // the release starts the store delay; a new press cancels it until the next release
            if (st.key_prev)
            begin
                next_st.store_pend = 1'b1;
                next_st.store_cnt = 32'h0;
            end
            else if (st.store_pend)
            begin
                if (st.store_cnt >= STORE_CYC - 32'h1)
                begin
                    next_st.store_pend = 1'b0;
                    next_st.store_pulse = 1'b1;
                end
                else
                begin
                    next_st.store_cnt = st.store_cnt + 32'h1;
                end
            end
        end

        // register writes take effect at the access edge
        if (wr_acc)
        begin
            case (i_paddr)
                okf_pkg::CTRL_OFS:
                begin
                    next_st.lr_en = i_pwdata[okf_pkg::LR_EN_BIT];
                    next_st.stop_en = i_pwdata[okf_pkg::STOP_EN_BIT];
                    next_st.direct = i_pwdata[okf_pkg::DIRECT_BIT];
                    next_st.action = i_pwdata[okf_pkg::ACTION_LSB +: 2];
                end
                okf_pkg::SOURCE_OFS:
                begin
                    next_st.run_sel = i_pwdata[okf_pkg::RUN_SEL_LSB +: 2];
                    next_st.ref_sel = i_pwdata[okf_pkg::REF_SEL_LSB +: 2];
                end
                okf_pkg::INIT_OFS:
                begin
                    if (i_pwdata[15:0] == okf_pkg::INIT_USER)
                    begin
                        next_st.reload_pulse = st.saved;
                        next_st.refused = !st.saved;
                    end
                end
                okf_pkg::ELAPSED_OFS: next_st.elapsed = i_pwdata[15:0];
                okf_pkg::FAN_OFS: next_st.fan = i_pwdata[15:0];
                okf_pkg::SCALE_OFS: next_st.scale = i_pwdata[15:0];
                okf_pkg::MONITOR_OFS:
                begin
                    next_st.pon_mon = i_pwdata[2:0];
                    next_st.user_mon = i_pwdata[okf_pkg::USER_MON_LSB +: 8];
                end
                okf_pkg::FMAX_OFS: next_st.fmax = i_pwdata[15:0];
                default: next_st.refused = st.refused;
            endcase
        end

        // a lowered fmax pulls the reference down with it
        if (next_st.freq > next_st.fmax)
        begin
            next_st.freq = next_st.fmax;
        end

        next_st.monitor = (st.pon_mon == okf_pkg::MON_USER) ? st.user_mon :
            {5'h00, st.pon_mon};

        next_st.rdata = 32'h0;
        if (i_psel && !i_penable && !i_pwrite)
        begin
            case (i_paddr)
                okf_pkg::CTRL_OFS: next_st.rdata = {26'h0, st.action, 1'b0,
                    st.direct, st.stop_en, st.lr_en};
                okf_pkg::SOURCE_OFS: next_st.rdata = {26'h0, st.ref_sel,
                    2'h0, st.run_sel};
                okf_pkg::ELAPSED_OFS: next_st.rdata = {16'h0, st.elapsed};
                okf_pkg::FAN_OFS: next_st.rdata = {16'h0, st.fan};
                okf_pkg::SCALE_OFS: next_st.rdata = {16'h0, st.scale};
                okf_pkg::MONITOR_OFS: next_st.rdata = {16'h0, st.user_mon,
                    5'h00, st.pon_mon};
                okf_pkg::FREQ_OFS: next_st.rdata = {16'h0, st.freq};
                okf_pkg::STATUS_OFS: next_st.rdata = {27'h0, st.store_pend,
                    i_running, st.local_mode, st.refused, st.saved};
                okf_pkg::FMAX_OFS: next_st.rdata = {16'h0, st.fmax};
                default: next_st.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_reset)
    begin
        if (i_reset)
        begin
            st <= '0;
            st.lr_en <= okf_pkg::RST_LR_EN;
            st.stop_en <= okf_pkg::RST_STOP_EN;
            st.pon_mon <= okf_pkg::RST_PON_MON;
            st.fmax <= okf_pkg::RST_FMAX;
            st.monitor <= {5'h00, okf_pkg::RST_PON_MON};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_prdata = st.rdata;
    assign o_local_mode = st.local_mode;
    assign o_stop = st.stop;
    assign o_emergency_stop = st.estop;
    assign o_freq_ref = st.freq;
    assign o_store_ref = st.store_pulse;
    assign o_save_user_set = st.save_pulse;
    assign o_clear_user_set = st.clear_pulse;
    assign o_user_reload = st.reload_pulse;
    assign o_elapsed_hours = st.elapsed;
    assign o_fan_hours = st.fan;
    assign o_display_scaling = st.scale;
    assign o_monitor = st.monitor;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    lr_key_ignored_a: assert property (!st.lr_en && i_key_local_remote
        |=> $stable(o_local_mode)) else $error("disabled key switched mode");
    sources_held_a: assert property (!st.lr_en && !$past(st.lr_en)
        |-> $stable(o_local_mode)) else $error("source changed while locked");
    remote_estop_a: assert property (i_key_stop && st.stop_en
        && !st.local_mode && st.run_sel != 2'h0 |=> o_emergency_stop && !o_stop)
        else $error("remote stop key gave no emergency stop");
    stop_disabled_a: assert property (i_key_stop && !st.stop_en
        && !st.local_mode && st.run_sel != 2'h0 |=> !o_emergency_stop && !o_stop)
        else $error("disabled stop key acted");
    save_action_a: assert property (st.action == 2'h1
        |=> o_save_user_set && st.saved && st.action == 2'h0)
        else $error("save action not performed");
    clear_refuse_a: assert property (!st.saved && wr_acc
        && i_paddr == 8'h08 && i_pwdata[15:0] == 16'h0456
        |=> !o_user_reload && st.refused) else $error("init accepted unsaved");
    user_reload_a: assert property (st.saved && wr_acc
        && i_paddr == 8'h08 && i_pwdata[15:0] == 16'h0456 |=> o_user_reload)
        else $error("user reload missing");
    enter_only_a: assert property (!st.direct && !i_key_enter && !wr_acc
        |=> $stable(o_freq_ref)) else $error("reference moved without enter");
    first_step_a: assert property (st.direct && key_up && !st.key_prev
        && st.freq < st.fmax && !wr_acc |=> o_freq_ref == $past(st.freq) + 16'h1)
        else $error("first up step wrong");
    ref_bound_a: assert property (o_freq_ref <= st.fmax)
        else $error("reference above fmax");
    store_delay_a: assert property (o_store_ref |-> !held
        && !$past(held, 2)) else $error("store during key hold");
    preset_load_a: assert property (wr_acc && i_paddr == 8'h0c
        |=> o_elapsed_hours == $past(i_pwdata[15:0]))
        else $error("elapsed preset not loaded");
    run_reject_a: assert property (access && i_pwrite && i_running
        |-> o_pslverr ##1 $stable(st.scale)) else $error("write taken in run");
    pon_monitor_a: assert property (st.pon_mon == 3'h4
        |=> o_monitor == $past(st.user_mon)) else $error("wrong monitor");

    save_cov_c: cover property (o_save_user_set);
    estop_cov_c: cover property (o_emergency_stop);
    store_cov_c: cover property (o_store_ref);
    fast_cov_c: cover property (held && st.hold_cnt >= FIRST_CYC + SLOW_CYC);

endmodule

/* design/okf_pkg.sv */
package okf_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] SOURCE_OFS = 8'h04;
    localparam logic [7:0] INIT_OFS = 8'h08;
    localparam logic [7:0] ELAPSED_OFS = 8'h0c;
    localparam logic [7:0] FAN_OFS = 8'h10;
    localparam logic [7:0] SCALE_OFS = 8'h14;
    localparam logic [7:0] MONITOR_OFS = 8'h18;
    localparam logic [7:0] FREQ_OFS = 8'h1c;
    localparam logic [7:0] STATUS_OFS = 8'h20;
    localparam logic [7:0] FMAX_OFS = 8'h24;
    // control, source and monitor register fields
    localparam int LR_EN_BIT = 0;
    localparam int STOP_EN_BIT = 1;
    localparam int DIRECT_BIT = 2;
    localparam int ACTION_LSB = 4;
    localparam int RUN_SEL_LSB = 0;
    localparam int REF_SEL_LSB = 4;
    localparam int USER_MON_LSB = 8;
    // reset values
    localparam logic RST_LR_EN = 1'b1;
    localparam logic RST_STOP_EN = 1'b1;
    localparam logic [2:0] RST_PON_MON = 3'h1;
    localparam logic [15:0] RST_FMAX = 16'h1770;
    // codes
    localparam logic [1:0] ACTION_NONE = 2'h0;
    localparam logic [1:0] ACTION_SAVE = 2'h1;
    localparam logic [1:0] ACTION_CLEAR = 2'h2;
    localparam logic [15:0] INIT_USER = 16'h0456;
    localparam logic [2:0] MON_USER = 3'h4;
    localparam logic [1:0] RUN_PANEL = 2'h0;
    // timing in milliseconds and the derived cycle counts
    localparam longint CLK_HZ = 25000000;
    localparam longint FIRST_MS = 500;
    localparam longint STEP_MS = 80;
    localparam longint SLOW_MS = 3000;
    localparam longint FAST_MS = 10000;
    localparam longint STORE_MS = 5000;
    localparam logic [31:0] FIRST_CYC = 32'(FIRST_MS * CLK_HZ / 1000);
    localparam logic [31:0] STEP_CYC = 32'(STEP_MS * CLK_HZ / 1000);
    localparam logic [31:0] SLOW_CYC = 32'(SLOW_MS * CLK_HZ / 1000);
    localparam logic [31:0] STORE_CYC = 32'(STORE_MS * CLK_HZ / 1000);
    localparam logic [15:0] FAST_STEPS = 16'(FAST_MS / STEP_MS);
endpackage

/* sim/okf_panel_model.sv */
`timescale 1ns/1ps
// operator panel: key taps are one-cycle pulses, arrows are held levels
module okf_panel_model (
    input wire logic i_clock,
    output logic o_key_local_remote,
    output logic o_key_stop,
    output logic o_key_up,
    output logic o_key_down,
    output logic o_key_enter,
    output logic [15:0] o_key_value
);
    initial
    begin
        o_key_local_remote = 1'b0;
        o_key_stop = 1'b0;
        o_key_up = 1'b0;
        o_key_down = 1'b0;
        o_key_enter = 1'b0;
        o_key_value = 16'h0000;
    end

    // 0 local/remote, 1 stop, other enter with a value
    task automatic tap(input int which, input logic [15:0] val);
        @(posedge i_clock);
        case (which)
            0: o_key_local_remote <= 1'b1;
            1: o_key_stop <= 1'b1;
            default:
            begin
                o_key_enter <= 1'b1;
                o_key_value <= val;
            end
        endcase
        @(posedge i_clock);
        o_key_local_remote <= 1'b0;
        o_key_stop <= 1'b0;
        o_key_enter <= 1'b0;
        // value bus is stale after enter, so show garbage, not the old value
        o_key_value <= ~val;
    endtask

    task automatic hold(input logic up, input logic dn);
        @(posedge i_clock);
        o_key_up <= up;
        o_key_down <= dn;
    endtask
endmodule

/* sim/tb_operator_keypad_function_control.sv */
`timescale 1ns/1ps
module tb_operator_keypad_function_control;
    localparam logic [31:0] T_STORE = 32'd30;
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [31:0] data;
        logic err;
    } okf_row_s;
    logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, running = 1'b0, hour_tick = 1'b0, fan_on = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, k_lr, k_stop, k_up, k_dn, k_ent;
    logic local_mode, stop, estop, store, save, clr, reload;
    logic [15:0] k_val, freq, ehours, fhours, scaling;
    logic [7:0] monitor;
    int num_errors = 0, n_compared = 0;
    int n_save = 0, n_clr = 0, n_rel = 0, n_store = 0, n_stop = 0, n_es = 0;
    int s;
    okf_row_s rows [0:15];

    always #20 clock = ~clock;

    always @(posedge clock)
    begin
        n_save += int'(save === 1'b1);
        n_clr += int'(clr === 1'b1);
        n_rel += int'(reload === 1'b1);
        n_store += int'(store === 1'b1);
        n_stop += int'(stop === 1'b1);
        n_es += int'(estop === 1'b1);
    end

    okf_keypad #(.FIRST_CYC(32'd20), .STEP_CYC(32'd4), .SLOW_CYC(32'd40),
        .STORE_CYC(T_STORE)) u_dut (.i_clock(clock), .i_reset(reset),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_running(running),
        .i_hour_tick(hour_tick), .i_fan_on(fan_on),
        .i_key_local_remote(k_lr), .i_key_stop(k_stop), .i_key_up(k_up),
        .i_key_down(k_dn), .i_key_enter(k_ent), .i_key_value(k_val),
        .o_local_mode(local_mode), .o_stop(stop), .o_emergency_stop(estop),
        .o_freq_ref(freq), .o_store_ref(store), .o_save_user_set(save),
        .o_clear_user_set(clr), .o_user_reload(reload),
        .o_elapsed_hours(ehours), .o_fan_hours(fhours),
        .o_display_scaling(scaling), .o_monitor(monitor));

    okf_panel_model u_panel (.i_clock(clock), .o_key_local_remote(k_lr),
        .o_key_stop(k_stop), .o_key_up(k_up), .o_key_down(k_dn),
        .o_key_enter(k_ent), .o_key_value(k_val));

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            num_errors++;
        end
    endtask

    // held until pready is seen high at a rising edge
    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            num_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        wait_n(20000);
        num_errors++;
        test_done();
    end

    initial
    begin
        rows = '{
            '{okf_pkg::CTRL_OFS, 1'b0, 32'h3, 1'b0},
            '{okf_pkg::SOURCE_OFS, 1'b0, 32'h0, 1'b0},
            '{okf_pkg::MONITOR_OFS, 1'b0, 32'h1, 1'b0},
            '{okf_pkg::FMAX_OFS, 1'b0, 32'h1770, 1'b0},
            '{okf_pkg::FREQ_OFS, 1'b0, 32'h0, 1'b0},
            '{okf_pkg::STATUS_OFS, 1'b0, 32'h0, 1'b0},
            '{okf_pkg::ELAPSED_OFS, 1'b0, 32'h0, 1'b0},
            '{okf_pkg::FAN_OFS, 1'b0, 32'h0, 1'b0},
            '{okf_pkg::ELAPSED_OFS, 1'b1, 32'h1234, 1'b0},
            '{okf_pkg::ELAPSED_OFS, 1'b0, 32'h1234, 1'b0},
            '{okf_pkg::FAN_OFS, 1'b1, 32'hffff, 1'b0},
            '{okf_pkg::FAN_OFS, 1'b0, 32'hffff, 1'b0},
            '{okf_pkg::ELAPSED_OFS, 1'b1, 32'h0, 1'b0},
            '{okf_pkg::ELAPSED_OFS, 1'b0, 32'h0, 1'b0},
            '{okf_pkg::SCALE_OFS, 1'b1, 32'h2ee0, 1'b0},
            '{8'h28, 1'b0, 32'h0, 1'b1}};
        wait_n(8);
        reset <= 1'b0;
        foreach (rows[i])
        begin
            apb(rows[i].addr, rows[i].wr, rows[i].data);
            chk({31'h0, er}, {31'h0, rows[i].err});
            if (!rows[i].wr)
                chk(rd, rows[i].data);
        end
        chk({16'h0, scaling}, 32'h2ee0);
        wr(okf_pkg::MONITOR_OFS, 32'h0504);
        wait_n(2);
        chk({24'h0, monitor}, 32'h05);
        // local key toggles, then is ignored once disabled
        u_panel.tap(0, 16'h0);
        wait_n(2);
        chk({31'h0, local_mode}, 32'h1);
        u_panel.tap(0, 16'h0);
        wr(okf_pkg::CTRL_OFS, 32'h2);
        u_panel.tap(0, 16'h0);
        wait_n(2);
        chk({31'h0, local_mode}, 32'h0);
        for (int k = 1; k < 4; k++)
        begin
            wr(okf_pkg::SOURCE_OFS, 32'(k));
            s = n_es;
            u_panel.tap(1, 16'h0);
            wait_n(3);
            chk(32'(n_es - s), 32'h1);
        end
        wr(okf_pkg::CTRL_OFS, 32'h0);
        s = n_es;
        u_panel.tap(1, 16'h0);
        wait_n(3);
        chk(32'(n_es - s), 32'h0);
        // panel run source: the stop key gives a normal stop
        wr(okf_pkg::SOURCE_OFS, 32'h0);
        s = n_stop;
        u_panel.tap(1, 16'h0);
        wait_n(3);
        chk(32'(n_stop - s), 32'h1);
        // user set: refused before save, reload after, refused after clear
        wr(okf_pkg::INIT_OFS, 32'(okf_pkg::INIT_USER));
        rdc(okf_pkg::STATUS_OFS, 32'h2);
        wr(okf_pkg::CTRL_OFS, 32'h10);
        // the pulse trails the access edge by a cycle, its count one more
        wait_n(3);
        chk(32'(n_save), 32'h1);
        rdc(okf_pkg::CTRL_OFS, 32'h0);
        wr(okf_pkg::INIT_OFS, 32'(okf_pkg::INIT_USER));
        wait_n(2);
        chk(32'(n_rel), 32'h1);
        wr(okf_pkg::CTRL_OFS, 32'h20);
        wr(okf_pkg::INIT_OFS, 32'(okf_pkg::INIT_USER));
        wait_n(2);
        chk(32'(n_clr * 16 + n_rel), 32'h11);
        rdc(okf_pkg::CTRL_OFS, 32'h0);
        // writes locked out while running; hour counting
        @(posedge clock);
        running <= 1'b1;
        fan_on <= 1'b1;
        wr(okf_pkg::SCALE_OFS, 32'h1);
        chk({31'h0, er}, 32'h1);
        rdc(okf_pkg::SCALE_OFS, 32'h2ee0);
        @(posedge clock);
        hour_tick <= 1'b1;
        @(posedge clock);
        hour_tick <= 1'b0;
        running <= 1'b0;
        wait_n(2);
        chk({ehours, fhours}, 32'h0001ffff);
        // enter-only reference entry
        u_panel.tap(2, 16'h0100);
        u_panel.hold(1'b1, 1'b0);
        wait_n(30);
        chk({16'h0, freq}, 32'h0100);
        u_panel.hold(1'b0, 1'b0);
        wr(okf_pkg::FMAX_OFS, 32'h0800);
        wr(okf_pkg::CTRL_OFS, 32'h4);
        // direct mode: single step, slow stepping, fast ramp, saturation
        u_panel.hold(1'b1, 1'b0);
        wait_n(10);
        chk({16'h0, freq}, 32'h0101);
        wait_n(40);
        chk(32'(freq > 16'h0105 && freq < 16'h010b), 32'h1);
        wait_n(350);
        chk(32'(freq < 16'h0800), 32'h1);
        wait_n(200);
        chk({16'h0, freq}, 32'h0800);
        u_panel.hold(1'b0, 1'b0);
        s = n_store;
        wait_n(T_STORE - 3);
        chk(32'(n_store - s), 32'h0);
        wait_n(8);
        chk(32'(n_store - s), 32'h1);
        u_panel.hold(1'b0, 1'b1);
        wait_n(10);
        chk({16'h0, freq}, 32'h07ff);
        wait_n(700);
        chk({16'h0, freq}, 32'h0);
        u_panel.hold(1'b0, 1'b0);
        // second reset in mid-run
        @(posedge clock);
        reset <= 1'b1;
        wait_n(2);
        reset <= 1'b0;
        rdc(okf_pkg::CTRL_OFS, 32'h3);
        chk({24'h0, monitor}, 32'h01);
        test_done();
    end
endmodule
